// ---- design/emd_dispatcher.sv ----
// Explicit message object dispatcher with AXI4-Lite register access
// Contract
// - Vendor register class 0x64 reaches every motor register.
// - Vendor class accepts only set single 0x10 and get single 0xE.
// - Vendor instances 0x01 to 0xFF map onto motor registers 1 to 255.
// - Motor registers are 32 bits, numbered 1 to 255.
// - Identity is instance one only, all its attributes read-only.
// - Revision is 16 bits, major in first byte, minor in second.
// - Message router forwards each message to the addressed object.
// - Assembly 0x64 writes configured registers, 0x65 reads them.
// - Assembly attribute 3 gets or sets the whole 20-byte block.
// - Assembly attribute 4 is read-only, returns byte count as 16 bits.
// - Assembly uses the same configured register set as cyclic exchange.
// - TCP/IP attribute 2 is read-only and reports capability 5.
// - TCP/IP attribute 3 is settable; value 0 selects stored setup.
// - TCP/IP attribute 5 is settable and holds 22 bytes of setup.
// - Connected and unconnected requests are both accepted.
// - Vendor set writes the 32-bit data into the selected register.
//
// The implementer's own choices: register access over AXI4-Lite and the register addresses.
`timescale 1ns/1ps
module emd_dispatcher #(
  parameter int          ADDR_W    = 8,
  parameter logic [15:0] VENDOR_ID = 16'h0F0F, // Arbitrary value
  parameter logic [15:0] DEV_TYPE  = 16'h0002, // Arbitrary value
  parameter logic [15:0] PROD_CODE = 16'h0007, // Arbitrary value
  parameter logic [7:0]  REV_MAJOR = 8'h03, // Arbitrary value
  parameter logic [7:0]  REV_MINOR = 8'h02, // Arbitrary value
  parameter logic [31:0] SERIAL_NO = 32'h0000_1234, // Arbitrary value
  parameter logic [31:0] PROD_NAME = 32'h5356_4F45, // Arbitrary text
  parameter logic [31:0] LINK_MBPS = 32'h0000_0064
) (
  input  wire logic              aclk,
  input  wire logic              aresetn,
  input  wire logic [ADDR_W-1:0] s_axi_awaddr,
  input  wire logic              s_axi_awvalid,
  output logic                   s_axi_awready,
  input  wire logic [31:0]       s_axi_wdata,
  input  wire logic [3:0]        s_axi_wstrb,
  input  wire logic              s_axi_wvalid,
  output logic                   s_axi_wready,
  output logic [1:0]             s_axi_bresp,
  output logic                   s_axi_bvalid,
  input  wire logic              s_axi_bready,
  input  wire logic [ADDR_W-1:0] s_axi_araddr,
  input  wire logic              s_axi_arvalid,
  output logic                   s_axi_arready,
  output logic [31:0]            s_axi_rdata,
  output logic [1:0]             s_axi_rresp,
  output logic                   s_axi_rvalid,
  input  wire logic              s_axi_rready,
  output logic                   nv_cfg_sel
);
  localparam int DW = emd_pkg::DATA_WORDS;
  localparam int AW = emd_pkg::ASM_WORDS;

  if (ADDR_W < 8) begin : g_bad_addr
    $error("emd_dispatcher: ADDR_W must be at least 8");
  end

  typedef struct packed {
    logic                   aw_got;
    logic [7:0]             aw_addr;
    logic                   w_got;
    logic [31:0]            w_data;
    logic [3:0]             w_strb;
    logic                   bvalid;
    logic [1:0]             bresp;
    logic                   rvalid;
    logic [31:0]            rdata;
    logic [1:0]             rresp;
    logic [31:0]            req;
    logic                   conn;
    logic                   pend;
    logic                   done;
    logic [7:0]             gstat;
    logic [7:0]             rlen;
    logic [DW-1:0][31:0]    qdata;
    logic [DW-1:0][31:0]    rsp;
    logic [AW-1:0][7:0]     wmap;
    logic [AW-1:0][7:0]     rmap;
    logic [31:0]            cfg_ctrl;
    logic [DW-1:0][31:0]    ifcfg;
    logic [255:1][31:0]     mreg;
  } emd_state_t;

  emd_state_t s_q;
  emd_state_t s_d;

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] nw,
                                        input logic [3:0] strb);
    logic [31:0] r;
    r = old;
    for (int b = 0; b < 4; b++) begin
      if (strb[b]) begin
        r[b*8 +: 8] = nw[b*8 +: 8];
      end
    end
    return r;
  endfunction

  // Hit flag and word index of an address inside a block of n words
  function automatic logic [3:0] blk(input logic [7:0] a, input logic [7:0] base,
                                     input int n);
    logic [7:0] off;
    off = a - base;
    blk = {(a >= base) && (off < 8'(n * 4)) && (a[1:0] == 2'b00), off[4:2]};
  endfunction

  // Zero in the map ends the list; the later entries are discarded
  function automatic logic [15:0] asm_len(input logic [AW-1:0][7:0] m);
    logic live;
    asm_len = 16'h0000;
    live = 1'b1;
    for (int i = 0; i < AW; i++) begin
      live = live && (m[i] != 8'h00);
      if (live) begin
        asm_len = asm_len + 16'h0004;
      end
    end
  endfunction

  logic [7:0] cls;
  logic [7:0] inst;
  logic [7:0] attr;
  logic [7:0] svc;
  logic       is_get;
  logic       is_set;
  logic [7:0] wa;
  logic [7:0] ra;
  logic [3:0] hq;
  logic [3:0] hr;
  logic [3:0] hw;
  logic [3:0] hm;

  assign cls    = s_q.req[emd_pkg::REQ_CLS_LSB +: 8];
  assign inst   = s_q.req[emd_pkg::REQ_INST_LSB +: 8];
  assign attr   = s_q.req[emd_pkg::REQ_ATTR_LSB +: 8];
  assign svc    = s_q.req[emd_pkg::REQ_SVC_LSB +: 8];
  assign is_get = (svc == emd_pkg::SVC_GET);
  assign is_set = (svc == emd_pkg::SVC_SET);
  assign wa     = s_q.aw_addr;
  assign ra     = s_axi_araddr[7:0];

  always_comb begin
    logic live;
    logic [AW-1:0][7:0] map;
    live = 1'b1;
    map  = s_q.wmap;
    hq   = 4'h0;
    hr   = 4'h0;
    hw   = 4'h0;
    hm   = 4'h0;
    s_d  = s_q;
    // Write channel: address and data may arrive in either order
    if (s_axi_awvalid && s_axi_awready) begin
      s_d.aw_got  = 1'b1;
      s_d.aw_addr = s_axi_awaddr[7:0];
    end
    if (s_axi_wvalid && s_axi_wready) begin
      s_d.w_got  = 1'b1;
      s_d.w_data = s_axi_wdata;
      s_d.w_strb = s_axi_wstrb;
    end
    if (s_q.bvalid && s_axi_bready) begin
      s_d.bvalid = 1'b0;
    end
    if (s_q.aw_got && s_q.w_got && !s_q.bvalid) begin
      s_d.aw_got = 1'b0;
      s_d.w_got  = 1'b0;
      s_d.bvalid = 1'b1;
      s_d.bresp  = emd_pkg::RESP_OKAY;
      hq = blk(wa, emd_pkg::OFS_QDATA, DW);
      hw = blk(wa, emd_pkg::OFS_WMAP, AW);
      hm = blk(wa, emd_pkg::OFS_RMAP, AW);
      hr = blk(wa, emd_pkg::OFS_RSP, DW);
      if (wa == emd_pkg::OFS_CTRL) begin
        // Either path is served alike; the flag is only reported back
        if (s_q.w_strb[0] && s_q.w_data[emd_pkg::CTRL_GO_BIT]) begin
          s_d.pend = 1'b1;
          s_d.done = 1'b0;
          s_d.conn = s_q.w_data[emd_pkg::CTRL_CONN_BIT];
        end
      end else if (wa == emd_pkg::OFS_REQ) begin
        s_d.req = merge(s_q.req, s_q.w_data, s_q.w_strb);
      end else if (hq[3]) begin
        s_d.qdata[hq[2:0]] = merge(s_q.qdata[hq[2:0]], s_q.w_data, s_q.w_strb);
      end else if (hw[3]) begin
        if (s_q.w_strb[0]) s_d.wmap[hw[2:0]] = s_q.w_data[7:0];
      end else if (hm[3]) begin
        if (s_q.w_strb[0]) s_d.rmap[hm[2:0]] = s_q.w_data[7:0];
      end else if (wa != emd_pkg::OFS_STAT && !hr[3]) begin
        s_d.bresp = emd_pkg::RESP_SLVERR;
      end
    end
    // Read channel: one word answered per accepted address
    if (s_q.rvalid && s_axi_rready) begin
      s_d.rvalid = 1'b0;
    end
    if (s_axi_arvalid && s_axi_arready) begin
      s_d.rvalid = 1'b1;
      s_d.rresp  = emd_pkg::RESP_OKAY;
      s_d.rdata  = 32'h0000_0000;
      hq = blk(ra, emd_pkg::OFS_QDATA, DW);
      hr = blk(ra, emd_pkg::OFS_RSP, DW);
      hw = blk(ra, emd_pkg::OFS_WMAP, AW);
      hm = blk(ra, emd_pkg::OFS_RMAP, AW);
      if (ra == emd_pkg::OFS_CTRL) begin
        s_d.rdata[emd_pkg::CTRL_CONN_BIT] = s_q.conn;
      end else if (ra == emd_pkg::OFS_REQ) begin
        s_d.rdata = s_q.req;
      end else if (ra == emd_pkg::OFS_STAT) begin
        s_d.rdata[7:0] = s_q.gstat;
        s_d.rdata[emd_pkg::STAT_LEN_LSB +: 8] = s_q.rlen;
        s_d.rdata[emd_pkg::STAT_DONE_BIT] = s_q.done;
        s_d.rdata[emd_pkg::STAT_CONN_BIT] = s_q.conn;
        s_d.rdata[emd_pkg::STAT_NV_BIT] = (s_q.cfg_ctrl == emd_pkg::CFG_CTRL_NV);
      end else if (hq[3]) begin
        s_d.rdata = s_q.qdata[hq[2:0]];
      end else if (hr[3]) begin
        s_d.rdata = s_q.rsp[hr[2:0]];
      end else if (hw[3]) begin
        s_d.rdata[7:0] = s_q.wmap[hw[2:0]];
      end else if (hm[3]) begin
        s_d.rdata[7:0] = s_q.rmap[hm[2:0]];
      end else begin
        s_d.rresp = emd_pkg::RESP_SLVERR;
      end
    end
    // Request execution; an error leaves every stored value untouched
    if (s_q.pend) begin
      s_d.pend  = 1'b0;
      s_d.done  = 1'b1;
      s_d.gstat = emd_pkg::ST_OK;
      s_d.rlen  = 8'h00;
      s_d.rsp   = '0;
      if (!(is_get || is_set)) begin
        s_d.gstat = emd_pkg::ST_SVC;
      end else begin
        case (cls)
          emd_pkg::CLS_VREG: begin
            if (inst == 8'h00) begin
              s_d.gstat = emd_pkg::ST_PATH;
            end else if (attr != 8'h01) begin
              s_d.gstat = emd_pkg::ST_ATTR;
            end else if (is_get) begin
              s_d.rsp[0] = s_q.mreg[inst];
              s_d.rlen   = emd_pkg::LEN_WORD;
            end else begin
              s_d.mreg[inst] = s_q.qdata[0];
            end
          end
          emd_pkg::CLS_IDENT: begin
            if (inst != emd_pkg::INST_ONE) begin
              s_d.gstat = emd_pkg::ST_PATH;
            end else if (attr == 8'h00 || attr > 8'h07) begin
              s_d.gstat = emd_pkg::ST_ATTR;
            end else if (is_set) begin
              s_d.gstat = emd_pkg::ST_NOSET;
            end else begin
              s_d.rlen = emd_pkg::LEN_HALF;
              case (attr)
                8'h01: s_d.rsp[0] = {16'h0000, VENDOR_ID};
                8'h02: s_d.rsp[0] = {16'h0000, DEV_TYPE};
                8'h03: s_d.rsp[0] = {16'h0000, PROD_CODE};
                8'h04: s_d.rsp[0] = {16'h0000, REV_MINOR, REV_MAJOR};
                8'h05: s_d.rsp[0] = {31'h0, 1'b1};
                8'h06: begin
                  s_d.rsp[0] = SERIAL_NO;
                  s_d.rlen   = emd_pkg::LEN_WORD;
                end
                default: begin
                  s_d.rsp[0] = PROD_NAME;
                  s_d.rlen   = emd_pkg::LEN_WORD;
                end
              endcase
            end
          end
          emd_pkg::CLS_ASM: begin
            if (inst == emd_pkg::INST_ASM_RD) map = s_q.rmap;
            if (inst != emd_pkg::INST_ASM_WR && inst != emd_pkg::INST_ASM_RD) begin
              s_d.gstat = emd_pkg::ST_PATH;
            end else if (attr == 8'h04) begin
              if (is_set) begin
                s_d.gstat = emd_pkg::ST_NOSET;
              end else begin
                s_d.rsp[0] = {16'h0000, asm_len(map)};
                s_d.rlen   = emd_pkg::LEN_HALF;
              end
            end else if (attr != 8'h03) begin
              s_d.gstat = emd_pkg::ST_ATTR;
            end else if (is_set && inst == emd_pkg::INST_ASM_RD) begin
              s_d.gstat = emd_pkg::ST_NOSET;
            end else begin
              s_d.rlen = emd_pkg::ASM_BYTES;
              for (int i = 0; i < AW; i++) begin
                live = live && (map[i] != 8'h00);
                if (live && is_get) s_d.rsp[i] = s_q.mreg[map[i]];
                if (live && is_set) s_d.mreg[map[i]] = s_q.qdata[i];
              end
            end
          end
          emd_pkg::CLS_TCP: begin
            if (inst != emd_pkg::INST_ONE) begin
              s_d.gstat = emd_pkg::ST_PATH;
            end else if (attr == 8'h01 || attr == 8'h02) begin
              if (is_set) begin
                s_d.gstat = emd_pkg::ST_NOSET;
              end else begin
                s_d.rsp[0] = (attr == 8'h02) ? emd_pkg::TCP_CAPAB : emd_pkg::TCP_STATUS;
                s_d.rlen   = emd_pkg::LEN_WORD;
              end
            end else if (attr == 8'h03) begin
              if (is_set) s_d.cfg_ctrl = s_q.qdata[0];
              s_d.rsp[0] = s_q.cfg_ctrl;
              s_d.rlen   = is_get ? emd_pkg::LEN_WORD : 8'h00;
            end else if (attr == 8'h05) begin
              if (is_set) begin
                s_d.ifcfg = s_q.qdata;
                s_d.ifcfg[DW-1][31:16] = 16'h0000;
              end else begin
                s_d.rsp  = s_q.ifcfg;
                s_d.rlen = emd_pkg::IFCFG_BYTES;
              end
            end else begin
              s_d.gstat = emd_pkg::ST_ATTR;
            end
          end
          emd_pkg::CLS_ELINK: begin
            if (inst != emd_pkg::INST_ONE) begin
              s_d.gstat = emd_pkg::ST_PATH;
            end else if (attr != 8'h01 && attr != 8'h02) begin
              s_d.gstat = emd_pkg::ST_ATTR;
            end else if (is_set) begin
              s_d.gstat = emd_pkg::ST_NOSET;
            end else begin
              s_d.rsp[0] = (attr == 8'h01) ? LINK_MBPS : 32'h0000_0001;
              s_d.rlen   = emd_pkg::LEN_WORD;
            end
          end
          // The router only forwards; it serves no attribute itself
          emd_pkg::CLS_ROUTER: s_d.gstat = emd_pkg::ST_ATTR;
          default:             s_d.gstat = emd_pkg::ST_PATH;
        endcase
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_q          <= '0;
      s_q.cfg_ctrl <= emd_pkg::CFG_CTRL_RST;
      s_q.wmap     <= {AW{emd_pkg::MAP_RST}};
      s_q.rmap     <= {AW{emd_pkg::MAP_RST}};
    end else begin
      s_q <= s_d;
    end
  end

  // Handshakes are combinational; one write and one read in flight
  assign s_axi_awready = !s_q.aw_got && !s_q.bvalid;
  assign s_axi_wready  = !s_q.w_got && !s_q.bvalid;
  assign s_axi_arready = !s_q.rvalid;
  assign s_axi_bvalid  = s_q.bvalid;
  assign s_axi_bresp   = s_q.bresp;
  assign s_axi_rvalid  = s_q.rvalid;
  assign s_axi_rdata   = s_q.rdata;
  assign s_axi_rresp   = s_q.rresp;
  assign nv_cfg_sel    = (s_q.cfg_ctrl == emd_pkg::CFG_CTRL_NV);

  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  property p_vreg_get;
    s_q.pend && cls == emd_pkg::CLS_VREG && is_get && inst != 8'h00 && attr == 8'h01
      |=> s_q.gstat == emd_pkg::ST_OK && s_q.rlen == 8'h04
          && s_q.rsp[0] == $past(s_q.mreg[inst]);
  endproperty
  a_vreg_get: assert property (p_vreg_get) else $error("vendor get wrong");

  property p_vreg_svc;
    s_q.pend && cls == emd_pkg::CLS_VREG && !is_get && !is_set
      |=> s_q.gstat == emd_pkg::ST_SVC && s_q.done;
  endproperty
  a_vreg_svc: assert property (p_vreg_svc) else $error("bad service accepted");

  property p_inst_zero;
    s_q.pend && cls == emd_pkg::CLS_VREG && inst == 8'h00 && (is_get || is_set)
      |=> s_q.gstat == emd_pkg::ST_PATH;
  endproperty
  a_inst_zero: assert property (p_inst_zero) else $error("register 0 accepted");

  property p_vreg_set;
    logic [7:0] i;
    logic [31:0] v;
    (s_q.pend && cls == emd_pkg::CLS_VREG && is_set && inst != 8'h00 && attr == 8'h01,
     i = inst, v = s_q.qdata[0]) |=> ##1 s_q.mreg[i] == v;
  endproperty
  a_vreg_set: assert property (p_vreg_set) else $error("register not written");

  property p_ident_ro;
    s_q.pend && cls == emd_pkg::CLS_IDENT && inst == 8'h01 && is_set
      && attr >= 8'h01 && attr <= 8'h07 |=> s_q.gstat == emd_pkg::ST_NOSET;
  endproperty
  a_ident_ro: assert property (p_ident_ro) else $error("identity written");

  property p_rev;
    s_q.pend && cls == emd_pkg::CLS_IDENT && inst == 8'h01 && is_get && attr == 8'h04
      |=> s_q.rsp[0][7:0] == REV_MAJOR && s_q.rsp[0][15:8] == REV_MINOR
          && s_q.rlen == 8'h02;
  endproperty
  a_rev: assert property (p_rev) else $error("revision layout wrong");

  property p_asm_len;
    s_q.pend && cls == emd_pkg::CLS_ASM && attr == 8'h03 && is_get
      && (inst == 8'h64 || inst == 8'h65) |=> s_q.rlen == 8'h14;
  endproperty
  a_asm_len: assert property (p_asm_len) else $error("assembly size wrong");

  property p_capab;
    s_q.pend && cls == emd_pkg::CLS_TCP && inst == 8'h01 && is_get && attr == 8'h02
      |=> s_q.rsp[0] == 32'h0000_0005;
  endproperty
  a_capab: assert property (p_capab) else $error("capability wrong");

  property p_nvsel;
    s_q.pend && cls == emd_pkg::CLS_TCP && inst == 8'h01 && is_set && attr == 8'h03
      |=> nv_cfg_sel == ($past(s_q.qdata[0]) == 32'h0);
  endproperty
  a_nvsel: assert property (p_nvsel) else $error("setup select wrong");

  property p_err_keep;
    s_q.pend ##1 s_q.gstat != emd_pkg::ST_OK
      |-> s_q.mreg == $past(s_q.mreg) && s_q.cfg_ctrl == $past(s_q.cfg_ctrl);
  endproperty
  a_err_keep: assert property (p_err_keep) else $error("error changed state");

  property p_bhold;
    s_q.bvalid && !s_axi_bready |=> s_q.bvalid;
  endproperty
  a_bhold: assert property (p_bhold) else $error("write answer dropped");

  c_vset: cover property (s_q.pend && cls == emd_pkg::CLS_VREG && is_set);
  c_asm:  cover property (s_q.pend && cls == emd_pkg::CLS_ASM && is_get ##1 s_q.done);
  c_err:  cover property (s_q.done && s_q.gstat == emd_pkg::ST_SVC);
  c_tcp:  cover property (s_q.pend && cls == emd_pkg::CLS_TCP && attr == 8'h05 && is_set);
endmodule

// ---- design/emd_pkg.sv ----
// Constants for the explicit message object dispatcher
package emd_pkg;
  // Register bus byte offsets
  localparam logic [7:0] OFS_CTRL    = 8'h00;
  localparam logic [7:0] OFS_REQ     = 8'h04;
  localparam logic [7:0] OFS_STAT    = 8'h08;
  localparam logic [7:0] OFS_QDATA   = 8'h20;
  localparam logic [7:0] OFS_RSP     = 8'h40;
  localparam logic [7:0] OFS_WMAP    = 8'h60;
  localparam logic [7:0] OFS_RMAP    = 8'h80;
  // Request word fields
  localparam int REQ_CLS_LSB  = 0;
  localparam int REQ_INST_LSB = 8;
  localparam int REQ_ATTR_LSB = 16;
  localparam int REQ_SVC_LSB  = 24;
  // Control and status bit positions
  localparam int CTRL_GO_BIT   = 0;
  localparam int CTRL_CONN_BIT = 1;
  localparam int STAT_LEN_LSB  = 8;
  localparam int STAT_DONE_BIT = 16;
  localparam int STAT_CONN_BIT = 17;
  localparam int STAT_NV_BIT   = 18;
  // Object classes
  localparam logic [7:0] CLS_IDENT  = 8'h01;
  localparam logic [7:0] CLS_ROUTER = 8'h02;
  localparam logic [7:0] CLS_ASM    = 8'h04;
  localparam logic [7:0] CLS_TCP    = 8'hF5;
  localparam logic [7:0] CLS_ELINK  = 8'hF6;
  localparam logic [7:0] CLS_VREG   = 8'h64;
  // Services
  localparam logic [7:0] SVC_SET = 8'h10;
  localparam logic [7:0] SVC_GET = 8'h0E;
  // Instances
  localparam logic [7:0] INST_ONE    = 8'h01;
  localparam logic [7:0] INST_ASM_WR = 8'h64;
  localparam logic [7:0] INST_ASM_RD = 8'h65;
  // Answer status codes
  localparam logic [7:0] ST_OK       = 8'h00;
  localparam logic [7:0] ST_PATH     = 8'h05;
  localparam logic [7:0] ST_SVC      = 8'h08;
  localparam logic [7:0] ST_NOSET    = 8'h0E;
  localparam logic [7:0] ST_ATTR     = 8'h14;
  // Object contents
  localparam int          ASM_WORDS   = 5;
  localparam logic [7:0]  ASM_BYTES   = 8'h14;
  localparam logic [7:0]  IFCFG_BYTES = 8'h16;
  localparam int          DATA_WORDS  = 6;
  localparam logic [31:0] TCP_CAPAB   = 32'h0000_0005;
  localparam logic [31:0] TCP_STATUS  = 32'h0000_0001;
  localparam logic [31:0] CFG_CTRL_NV = 32'h0000_0000;
  localparam logic [31:0] CFG_CTRL_RST = 32'h0000_0000;
  localparam logic [7:0]  MAP_RST     = 8'h00;
  localparam logic [7:0]  LEN_WORD    = 8'h04;
  localparam logic [7:0]  LEN_HALF    = 8'h02;
  // AXI responses
  localparam logic [1:0] RESP_OKAY   = 2'b00;
  localparam logic [1:0] RESP_SLVERR = 2'b10;
endpackage

// ---- testbench/emd_dispatcher_tb.sv ----
// Self-checking bench for the explicit message object dispatcher
`timescale 1ns/1ps
module emd_dispatcher_tb;
  logic        aclk, aresetn, cn;
  logic [7:0]  awaddr, araddr;
  logic [31:0] wdata, rdata, st, ans;
  logic [3:0]  wstrb;
  logic [1:0]  bresp, rresp, r;
  logic        awvalid, awready, wvalid, wready, bvalid, bready;
  logic        arvalid, arready, rvalid, rready, nv_cfg_sel;
  int          n_mismatch, comparisons;
  emd_dispatcher emd_dispatcher_i (.aclk(aclk), .aresetn(aresetn),
    .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid), .s_axi_awready(awready),
    .s_axi_wdata(wdata), .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid),
    .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid),
    .s_axi_bready(bready), .s_axi_araddr(araddr), .s_axi_arvalid(arvalid),
    .s_axi_arready(arready), .s_axi_rdata(rdata), .s_axi_rresp(rresp),
    .s_axi_rvalid(rvalid), .s_axi_rready(rready), .nv_cfg_sel(nv_cfg_sel));
  emd_scanner emd_scanner_i (.aclk, .awaddr, .awvalid, .awready, .wdata, .wstrb,
    .wvalid, .wready, .bresp, .bvalid, .bready, .araddr, .arvalid, .arready,
    .rdata, .rresp, .rvalid, .rready);
  initial begin
    aclk = 1'b0;
    forever #12.5 aclk = ~aclk;
  end
  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] s);
    comparisons++;
    if (s !== e) begin
      $display("mismatch %s expected %h seen %h", nm, e, s);
      n_mismatch++;
    end
  endtask
  task automatic cst(input logic [7:0] e);
    chk("status", {24'h0, e}, {24'h0, st[7:0]});
  endtask
  // Data word, request word, go, then status and first answer word
  task automatic req(input logic [7:0] c, i, at, sv, input logic [31:0] d);
    emd_scanner_i.wr(emd_pkg::OFS_QDATA, d, r);
    emd_scanner_i.wr(emd_pkg::OFS_REQ, {sv, at, i, c}, r);
    emd_scanner_i.wr(emd_pkg::OFS_CTRL, {30'h0, cn, 1'b1}, r);
    emd_scanner_i.rd(emd_pkg::OFS_STAT, st, r);
    emd_scanner_i.rd(emd_pkg::OFS_RSP, ans, r);
    chk("done", 32'h1, {31'h0, st[16]});
  endtask
  task automatic test_done;
    $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
    if (n_mismatch == 0 && comparisons > 0) $display("DONE - PASS");
    else $display("DONE - FAIL");
    $finish;
  endtask
  task automatic hang;
    $display("mismatch bus answer expected 1 seen 0");
    n_mismatch++;
    test_done();
  endtask
  task automatic t_vreg;
    cn = 1'b1;
    req(8'h64, 8'h02, 8'h01, 8'h10, 32'h1);
    cst(emd_pkg::ST_OK);
    chk("conn", 32'h1, {31'h0, st[17]});
    cn = 1'b0;
    req(8'h64, 8'hFF, 8'h01, 8'h10, 32'hA5C3_0F01);
    req(8'h64, 8'h02, 8'h01, 8'h0E, 32'h0);
    chk("reg2", 32'h1, ans);
    req(8'h64, 8'hFF, 8'h01, 8'h0E, 32'h0);
    chk("reg255", 32'hA5C3_0F01, ans);
    chk("len", 32'h4, {24'h0, st[15:8]});
    $display("t_vreg end");
  endtask
  task automatic t_bad;
    req(8'h64, 8'h02, 8'h01, 8'h01, 32'h7);
    cst(emd_pkg::ST_SVC);
    req(8'h64, 8'h02, 8'h02, 8'h10, 32'h7);
    cst(emd_pkg::ST_ATTR);
    req(8'h64, 8'h00, 8'h01, 8'h0E, 32'h0);
    cst(emd_pkg::ST_PATH);
    req(8'h64, 8'h02, 8'h01, 8'h0E, 32'h0);
    chk("reg2", 32'h1, ans);
    $display("t_bad end");
  endtask
  task automatic t_tcp;
    chk("nv", 32'h1, {31'h0, nv_cfg_sel});
    req(8'hF5, 8'h01, 8'h02, 8'h0E, 32'h0);
    chk("capab", 32'h5, ans);
    req(8'hF5, 8'h01, 8'h02, 8'h10, 32'h9);
    cst(emd_pkg::ST_NOSET);
    req(8'hF5, 8'h01, 8'h03, 8'h10, 32'h1);
    chk("nv", 32'h0, {31'h0, nv_cfg_sel});
    req(8'hF5, 8'h01, 8'h03, 8'h10, 32'h0);
    chk("nv", 32'h1, {31'h0, nv_cfg_sel});
    req(8'hF5, 8'h01, 8'h05, 8'h10, 32'hC0A8_0135);
    cst(emd_pkg::ST_OK);
    req(8'hF5, 8'h01, 8'h05, 8'h0E, 32'h0);
    chk("ifcfg", 32'hC0A8_0135, ans);
    chk("len", 32'h16, {24'h0, st[15:8]});
    $display("t_tcp end");
  endtask
  task automatic t_ident;
    req(8'h01, 8'h01, 8'h01, 8'h10, 32'h3);
    cst(emd_pkg::ST_NOSET);
    req(8'h01, 8'h01, 8'h04, 8'h0E, 32'h0);
    chk("rev", 32'h0203, ans);
    chk("len", 32'h2, {24'h0, st[15:8]});
    req(8'h01, 8'h02, 8'h01, 8'h0E, 32'h0);
    cst(emd_pkg::ST_PATH);
    req(8'h02, 8'h01, 8'h01, 8'h0E, 32'h0);
    cst(emd_pkg::ST_ATTR);
    $display("t_ident end");
  endtask
  task automatic t_asm;
    req(8'h04, 8'h65, 8'h04, 8'h0E, 32'h0);
    chk("bytes", 32'h0, ans);
    req(8'h04, 8'h64, 8'h04, 8'h10, 32'h0);
    cst(emd_pkg::ST_NOSET);
    emd_scanner_i.wr(emd_pkg::OFS_WMAP, 32'h2, r);
    req(8'h04, 8'h64, 8'h03, 8'h10, 32'h9);
    chk("len", 32'h14, {24'h0, st[15:8]});
    req(8'h64, 8'h02, 8'h01, 8'h0E, 32'h0);
    chk("reg2", 32'h9, ans);
    req(8'h04, 8'h64, 8'h04, 8'h0E, 32'h0);
    chk("bytes", 32'h4, ans);
    emd_scanner_i.wr(emd_pkg::OFS_RMAP, 32'h2, r);
    chk("bresp", {30'h0, emd_pkg::RESP_OKAY}, {30'h0, r});
    req(8'h04, 8'h65, 8'h03, 8'h0E, 32'h0);
    chk("asm", 32'h9, ans);
    chk("len", 32'h14, {24'h0, st[15:8]});
    emd_scanner_i.wr(8'hF0, 32'h0, r);
    chk("bresp", {30'h0, emd_pkg::RESP_SLVERR}, {30'h0, r});
    emd_scanner_i.rd(8'hF0, st, r);
    chk("rresp", {30'h0, emd_pkg::RESP_SLVERR}, {30'h0, r});
    $display("t_asm end");
  endtask
  initial begin
    n_mismatch = 0;
    comparisons = 0;
    cn = 1'b0;
    aresetn = 1'b0;
    repeat (3) @(posedge aclk);
    aresetn <= 1'b1;
    t_vreg();
    t_bad();
    t_tcp();
    t_ident();
    t_asm();
    test_done();
  end
endmodule

// ---- testbench/emd_scanner.sv ----
// Scanner model issuing explicit requests over AXI4-Lite
`timescale 1ns/1ps
module emd_scanner (
  input  wire logic        aclk,
  output logic [7:0]       awaddr,
  output logic             awvalid,
  input  wire logic        awready,
  output logic [31:0]      wdata,
  output logic [3:0]       wstrb,
  output logic             wvalid,
  input  wire logic        wready,
  input  wire logic [1:0]  bresp,
  input  wire logic        bvalid,
  output logic             bready,
  output logic [7:0]       araddr,
  output logic             arvalid,
  input  wire logic        arready,
  input  wire logic [31:0] rdata,
  input  wire logic [1:0]  rresp,
  input  wire logic        rvalid,
  output logic             rready
);
  initial begin
    awaddr = 8'h00;
    awvalid = 1'b0;
    wdata = 32'h0;
    wstrb = 4'hF;
    wvalid = 1'b0;
    bready = 1'b0;
    araddr = 8'h00;
    arvalid = 1'b0;
    rready = 1'b0;
  end
  // Ready is read right after the edge, so it still shows the sampled value
  task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (awvalid && awready) awvalid <= 1'b0;
      if (wvalid && wready) wvalid <= 1'b0;
      if (bvalid) begin
        r = bresp;
        bready <= 1'b0;
        break;
      end
    end
    if (n == 64) emd_dispatcher_tb.hang();
  endtask
  task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    int n;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    for (n = 0; n < 64; n++) begin
      @(posedge aclk);
      if (arvalid && arready) arvalid <= 1'b0;
      if (rvalid) begin
        d = rdata;
        r = rresp;
        rready <= 1'b0;
        break;
      end
    end
    if (n == 64) emd_dispatcher_tb.hang();
  endtask
endmodule
